//--- nvsram_special_command_unit.sv
// special command interpreter of a serial nonvolatile sram
// assumes the memory core and nonvolatile engine act on store_req/recall_req;
// serial pins are oversampled by clk_sys, so sck must stay well below 10 MHz
`timescale 1ns/1ps
module nvsram_special_command_unit
   import nvsram_cmd_pkg::*;
#(
   parameter bit          has_autosave    = 1'b1,
   parameter int unsigned seq_busy_cycles = SEQ_BUSY_CYC,
   parameter int unsigned wake_cycles     = WAKE_CYC,
   parameter logic [2:0]  mfr_bank        = 3'h1,     // arbitrary value
   parameter logic [7:0]  mfr_number      = 8'h5a,    // arbitrary value
   parameter logic [13:0] product_code    = 14'h0123, // arbitrary value
   parameter logic [3:0]  density_code    = 4'h1      // arbitrary value
)(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   input  wire logic        sram_written,
   input  wire logic        lock_set,
   input  wire logic        lock_clr,
   output logic             write_enable_latch,
   output logic             power_loss_autosave,
   output logic             serial_lock_bit,
   output logic             serial_lock_stored,
   output logic             busy,
   output logic             sleeping,
   output logic             store_req,
   output logic             recall_req,
   output logic             sn_overrun,
   output logic [31:0]      device_id
);
   localparam int WAKE_MAX = 1000;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   function automatic logic is_special(input logic [7:0] op);
      is_special = (op == OP_STORE) || (op == OP_RECALL) ||
                   (op == OP_AS_ON) || (op == OP_AS_OFF);
   endfunction : is_special

   logic [2:0]  pins_s;
   logic        sck_s;
   logic        cs_n_s;
   logic        si_s;
   logic        sck_d;
   logic        cs_n_d;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_fall;
   logic        cs_rise;
   logic        frame_ok;
   logic        active;
   logic [2:0]  bit_cnt;
   logic [3:0]  byte_cnt;
   logic [7:0]  rx_shift;
   logic [7:0]  rx_byte;
   logic [7:0]  cmd;
   logic        cmd_valid;
   logic        byte_done;
   logic        cmd_end;
   logic        exec;
   logic        sleep_go;
   logic        rd_mode;
   logic        data_ph;
   logic [3:0]  rd_idx;
   logic [7:0]  tx_shift;
   logic [7:0]  rd_byte;
   logic [15:0] busy_cnt;
   logic [15:0] wake_cnt;
   logic        waking;
   logic [7:0]  sn [SN_BYTES];
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [10:0] fifo_in_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [10:0] fifo_out_data;

   // pins are asynchronous; idle chip select is high
   bit_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h2)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .d       ({sck, cs_n, si}),
      .q       (pins_s)
   );

   assign sck_s  = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign si_s   = pins_s[0];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sck_d  <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sck_d  <= sck_s;
         cs_n_d <= cs_n_s;
      end
   end

   assign sck_rise = sck_s && !sck_d;
   assign sck_fall = !sck_s && sck_d;
   assign cs_fall  = cs_n_d && !cs_n_s;
   assign cs_rise  = !cs_n_d && cs_n_s;
   // asleep, frame_ok stays low so clock and data are ignored
   assign active   = !cs_n_s && frame_ok;

   // a frame is only served when awake and idle at its start
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         frame_ok <= 1'b0;
      end else if (cs_fall) begin
         frame_ok <= !sleeping && !busy;
      end else if (cs_rise) begin
         frame_ok <= 1'b0;
      end
   end

   assign rx_byte   = {rx_shift[6:0], si_s};
   assign byte_done = sck_rise && active && (bit_cnt == 3'h7);

   // byte framing and opcode capture
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bit_cnt   <= 3'h0;
         byte_cnt  <= 4'h0;
         rx_shift  <= 8'h00;
         cmd       <= 8'h00;
         cmd_valid <= 1'b0;
      end else if (cs_fall) begin
         bit_cnt   <= 3'h0;
         byte_cnt  <= 4'h0;
         cmd_valid <= 1'b0;
      end else if (sck_rise && active) begin
         rx_shift <= rx_byte;
         bit_cnt  <= bit_cnt + 3'h1;
         if (bit_cnt == 3'h7) begin
            if (byte_cnt != 4'hf) begin
               byte_cnt <= byte_cnt + 4'h1;
            end
            if (byte_cnt == 4'h0) begin
               cmd       <= rx_byte;
               cmd_valid <= 1'b1;
            end
         end
      end
   end

   // special commands, sleep and write enable act only at the end of their frame; serial number bytes move during it
   assign cmd_end  = cs_rise && frame_ok && cmd_valid;
   assign exec     = cmd_end && write_enable_latch && is_special(cmd);
   assign sleep_go = cmd_end && (cmd == OP_SLEEP);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         write_enable_latch <= 1'b0;
      end else if (cmd_end) begin
         if (cmd == OP_WRITE_EN) begin
            write_enable_latch <= 1'b1;
         end else if (is_special(cmd) || (cmd == OP_SN_WR)) begin
            write_enable_latch <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         store_req  <= 1'b0;
         recall_req <= 1'b0;
      end else begin
         store_req  <= (exec && (cmd == OP_STORE)) || (sleep_go && sram_written);
         recall_req <= exec && (cmd == OP_RECALL);
      end
   end

   // volatile only: reset reloads has_autosave, a store does not keep it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         power_loss_autosave <= has_autosave;
      end else if (exec && has_autosave) begin
         if (cmd == OP_AS_ON) begin
            power_loss_autosave <= 1'b1;
         end else if (cmd == OP_AS_OFF) begin
            power_loss_autosave <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt <= 16'h0000;
      end else if (exec && has_autosave && ((cmd == OP_AS_ON) || (cmd == OP_AS_OFF))) begin
         busy_cnt <= 16'(seq_busy_cycles);
      end else if (busy_cnt != 16'h0000) begin
         busy_cnt <= busy_cnt - 16'h0001;
      end
   end

   assign busy = (busy_cnt != 16'h0000);

   // sleep entry and wake-up; a frame arriving during wake-up is refused
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sleeping <= 1'b0;
         waking   <= 1'b0;
         wake_cnt <= 16'h0000;
      end else if (sleep_go) begin
         sleeping <= 1'b1;
      end else if (sleeping && !waking && cs_fall) begin
         waking   <= 1'b1;
         wake_cnt <= 16'(wake_cycles);
      end else if (waking) begin
         if (wake_cnt <= 16'h0001) begin
            waking   <= 1'b0;
            sleeping <= 1'b0;
         end else begin
            wake_cnt <= wake_cnt - 16'h0001;
         end
      end
   end

   // lock: clear allowed only before it was stored; set wins
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         serial_lock_bit    <= 1'b0;
         serial_lock_stored <= 1'b0;
      end else begin
         if (lock_clr && !serial_lock_stored) begin
            serial_lock_bit <= 1'b0;
         end
         if (lock_set) begin
            serial_lock_bit <= 1'b1;
         end
         if (store_req) begin
            serial_lock_stored <= serial_lock_stored || serial_lock_bit;
         end
      end
   end

   // serial write bytes queue with their index; drain pauses while busy
   assign fifo_in_valid = byte_done && cmd_valid && (cmd == OP_SN_WR) && (byte_cnt != 4'h0) &&
                          (byte_cnt <= 4'(SN_BYTES)) && write_enable_latch && !serial_lock_bit;
   assign fifo_in_data   = {3'(byte_cnt - 4'h1), rx_byte};
   assign fifo_out_ready = !busy;

   sync_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_sn_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // a full queue drops the byte; flag kept until the next frame
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sn_overrun <= 1'b0;
      end else begin
         if (cs_fall) begin
            sn_overrun <= 1'b0;
         end
         if (fifo_in_valid && !fifo_in_ready) begin
            sn_overrun <= 1'b1;
         end
      end
   end

   // no crc is computed; bytes are stored as given
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < SN_BYTES; i++) begin
            sn[i] <= SN_RESET;
         end
      end else if (fifo_out_valid && fifo_out_ready && !serial_lock_bit) begin
         sn[fifo_out_data[10:8]] <= fifo_out_data[7:0];
      end
   end

   // serial number read; fast read skips one dummy byte
   assign rd_mode = cmd_valid && ((cmd == OP_SN_RD) || (cmd == OP_SN_FRD));
   assign data_ph = rd_mode && (byte_cnt >= ((cmd == OP_SN_FRD) ? FRD_SKIP : RD_SKIP));
   assign rd_byte = (rd_idx < 4'(SN_BYTES)) ? sn[rd_idx[2:0]] : 8'h00;
   assign so_oe   = active && data_ph && !sleeping;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_idx   <= 4'h0;
         tx_shift <= 8'h00;
         so       <= 1'b0;
      end else if (cs_fall) begin
         rd_idx   <= 4'h0;
         tx_shift <= 8'h00;
         so       <= 1'b0;
      end else if (sck_fall && active && data_ph) begin
         if (bit_cnt == 3'h0) begin
            so       <= rd_byte[7];
            tx_shift <= {rd_byte[6:0], 1'b0};
            if (rd_idx != 4'(SN_BYTES)) begin
               rd_idx <= rd_idx + 4'h1;
            end
         end else begin
            so       <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
         end
      end
   end

   always_comb begin
      device_id = 32'h0000_0000;
      device_id[ID_MFR_MSB:ID_MFR_LSB]   = {mfr_bank, mfr_number};
      device_id[ID_PROD_MSB:ID_PROD_LSB] = product_code;
      device_id[ID_DENS_MSB:ID_DENS_LSB] = density_code;
      device_id[ID_REV_MSB:ID_REV_LSB]   = DIE_REV;
   end

   sequence s_cmd_end(logic [7:0] op);
      cs_rise && frame_ok && cmd_valid && (cmd == op);
   endsequence

   sequence s_wake_armed;
      sleeping && !waking && cs_fall;
   endsequence

   sequence s_woken;
      ##[1:WAKE_MAX] !sleeping;
   endsequence

   property p_store;
      s_cmd_end(OP_STORE) and write_enable_latch |=> store_req;
   endproperty
   a_store: assert property (p_store) else $error("store not issued");

   property p_recall;
      s_cmd_end(OP_RECALL) and write_enable_latch |=> recall_req ##1 !recall_req;
   endproperty
   a_recall: assert property (p_recall) else $error("recall not one pulse");

   property p_drop;
      s_cmd_end(OP_STORE) and !write_enable_latch |=> !store_req && !write_enable_latch;
   endproperty
   a_drop: assert property (p_drop) else $error("store ran without write enable");

   property p_wen_clear;
      cmd_end && is_special(cmd) |=> !write_enable_latch;
   endproperty
   a_wen_clear: assert property (p_wen_clear) else $error("write enable kept");

   property p_as_on;
      s_cmd_end(OP_AS_ON) and write_enable_latch |=> (power_loss_autosave == has_autosave);
   endproperty
   a_as_on: assert property (p_as_on) else $error("autosave on failed");

   property p_as_busy;
      has_autosave && exec && ((cmd == OP_AS_ON) || (cmd == OP_AS_OFF)) |=> busy [*8];
   endproperty
   a_as_busy: assert property (p_as_busy) else $error("no busy after autosave change");

   property p_as_default;
      $fell(sys_rst) |-> (power_loss_autosave == has_autosave);
   endproperty
   a_as_default: assert property (p_as_default) else $error("autosave default wrong");

   property p_sleep_quiet;
      sleeping |-> !so_oe && !fifo_in_valid;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");

   property p_wake;
      s_wake_armed |=> waking ##0 s_woken;
   endproperty
   a_wake: assert property (p_wake) else $error("wake-up did not finish");

   property p_lock;
      fifo_in_valid |-> !serial_lock_bit && write_enable_latch && (cmd == OP_SN_WR);
   endproperty
   a_lock: assert property (p_lock) else $error("serial write accepted wrongly");

   property p_no_wrap;
      sck_fall && active && data_ph && (bit_cnt == 3'h0) && (rd_idx == 4'(SN_BYTES)) |=> !so;
   endproperty
   a_no_wrap: assert property (p_no_wrap) else $error("serial read wrapped");

endmodule : nvsram_special_command_unit

//--- nvsram_cmd_pkg.sv
// constants for the special command unit of a serial nonvolatile sram
// assumes a 20 MHz system clock and a mode 0/3 serial link sampled by it
package nvsram_cmd_pkg;

   localparam logic [7:0] OP_STORE    = 8'h3c;
   localparam logic [7:0] OP_RECALL   = 8'h60;
   localparam logic [7:0] OP_AS_ON    = 8'h59;
   localparam logic [7:0] OP_AS_OFF   = 8'h19;
   localparam logic [7:0] OP_WRITE_EN = 8'h0a;
   localparam logic [7:0] OP_SLEEP    = 8'hb0;
   localparam logic [7:0] OP_SN_WR    = 8'hc2;
   localparam logic [7:0] OP_SN_RD    = 8'hc3;
   localparam logic [7:0] OP_SN_FRD   = 8'hc9;

   localparam int         SN_BYTES    = 8;
   localparam logic [7:0] SN_RESET    = 8'h00;
   localparam logic [3:0] RD_SKIP     = 4'h1;
   localparam logic [3:0] FRD_SKIP    = 4'h2;

   localparam int         ID_MFR_MSB  = 31;
   localparam int         ID_MFR_LSB  = 21;
   localparam int         ID_PROD_MSB = 20;
   localparam int         ID_PROD_LSB = 7;
   localparam int         ID_DENS_MSB = 6;
   localparam int         ID_DENS_LSB = 3;
   localparam int         ID_REV_MSB  = 2;
   localparam int         ID_REV_LSB  = 0;
   localparam logic [2:0] DIE_REV     = 3'h0;

   localparam int         CLK_PERIOD_NS = 50;
   localparam int         WAKE_NS       = 20000;
   localparam int         SEQ_BUSY_NS   = 500000;
   localparam int         WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SEQ_BUSY_CYC  = (SEQ_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int         FIFO_DEPTH  = 32;
   localparam int         FIFO_WIDTH  = 11;

endpackage : nvsram_cmd_pkg

//--- bit_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to clk_sys and change slowly
`timescale 1ns/1ps
module bit_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : bit_sync

//--- sync_fifo.sv
// single-clock fifo with valid/ready on both sides
// assumes both sides run on clk_sys
`timescale 1ns/1ps
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)(
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : sync_fifo

//--- nvsram_spi_host.sv
// spi host model driving the serial pins of the command unit
// assumes mode 0, sck of 400 ns, frames started by the bench through frame()
`timescale 1ns/1ps
module nvsram_spi_host (
   input  wire logic clk_sys,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   logic [7:0] tx [0:10];
   logic [7:0] rx [0:10];
   logic       oe_seen;

   initial begin
      sck     = 1'b0;
      cs_n    = 1'b1;
      si      = 1'b0;
      oe_seen = 1'b0;
   end

   // sck rests low between frames; released si shows the inverse of its last bit
   task automatic frame(input int nbytes);
      @(posedge clk_sys) #2;
      cs_n    = 1'b0;
      oe_seen = 1'b0;
      #400;
      for (int b = 0; b < nbytes; b++) begin
         for (int i = 7; i >= 0; i--) begin
            si = tx[b][i];
            #200 sck = 1'b1;
            // an undriven so reads as the inverse of its last value
            rx[b][i] = so_oe ? so : ~so;
            oe_seen  = oe_seen | so_oe;
            #200 sck = 1'b0;
         end
      end
      #200 cs_n = 1'b1;
      si = ~si;
      // long gap so the unit sees cs high for several clocks
      #400;
   endtask : frame
endmodule : nvsram_spi_host

//--- nvsram_special_command_unit_test.sv
// self-checking bench for the special command unit
// assumes the spi host model drives the pins; busy and wake counts shortened
`timescale 1ns/1ps
module nvsram_special_command_unit_test;
   import nvsram_cmd_pkg::*;
   localparam int BUSY_CYC = 20;
   localparam int WAKE_C   = 10;
   logic        clk_sys, sys_rst, sck, cs_n, si, so, so_oe, sram_written, lock_set, lock_clr;
   logic        wen, autosave, lock, lock_stored, busy, sleeping, store_req, recall_req, overrun;
   logic [31:0] device_id;
   int          err_total, n_tests, n_store, n_recall, ns, nr;
   int          seed = 32'h076f;
   logic [7:0]  sn   [0:7];
   logic [7:0]  ops  [0:3] = '{OP_STORE, OP_RECALL, OP_AS_OFF, OP_AS_ON};

   nvsram_special_command_unit #(.seq_busy_cycles(BUSY_CYC), .wake_cycles(WAKE_C)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
      .so_oe(so_oe), .sram_written(sram_written), .lock_set(lock_set), .lock_clr(lock_clr),
      .write_enable_latch(wen), .power_loss_autosave(autosave), .serial_lock_bit(lock),
      .serial_lock_stored(lock_stored), .busy(busy), .sleeping(sleeping),
      .store_req(store_req), .recall_req(recall_req), .sn_overrun(overrun), .device_id(device_id));

   nvsram_spi_host host (.clk_sys(clk_sys), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   // counted on the falling edge, away from the edge that launches the pulse
   always @(negedge clk_sys) begin
      if (store_req === 1'b1) n_store++;
      if (recall_req === 1'b1) n_recall++;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   task automatic send1(input logic [7:0] op);
      host.tx[0] = op;
      host.frame(1);
   endtask : send1

   task automatic pulse(input bit set);
      @(posedge clk_sys) #2;
      lock_set = set;
      lock_clr = ~set;
      @(posedge clk_sys) #2;
      lock_set = 1'b0;
      lock_clr = 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : pulse

   // random filler on si during data phase; device must ignore it
   task automatic read_sn(input logic [7:0] op, input int skip);
      host.tx[0] = op;
      for (int i = 1; i < 11; i++) host.tx[i] = 8'($random(seed));
      host.frame(skip + 9);
      for (int i = 0; i < 8; i++) chk("sn byte", {24'h0, sn[i]}, {24'h0, host.rx[skip + i]});
      chk("sn past end", 32'h0, {24'h0, host.rx[skip + 8]});
      chk("so_oe in read", 32'h1, {31'h0, host.oe_seen});
   endtask : read_sn

   task automatic write_sn(input bit takes);
      send1(OP_WRITE_EN);
      host.tx[0] = OP_SN_WR;
      for (int i = 0; i < 8; i++) begin
         host.tx[i + 1] = 8'($random(seed));
         if (takes) sn[i] = host.tx[i + 1];
      end
      host.frame(9);
      chk("wen after sn write", 32'h0, {31'h0, wen});
      chk("no overrun", 32'h0, {31'h0, overrun});
   endtask : write_sn

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   initial begin
      #3000000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      sys_rst      = 1'b1;
      sram_written = 1'b0;
      lock_set     = 1'b0;
      lock_clr     = 1'b0;
      err_total    = 0;
      n_tests      = 0;
      n_store      = 0;
      n_recall     = 0;
      repeat (3) @(posedge clk_sys);
      #2 sys_rst = 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("device id", {3'h1, 8'h5a, 14'h0123, 4'h1, DIE_REV}, device_id);
      chk("autosave at reset", 32'h1, {31'h0, autosave});
      for (int i = 0; i < 8; i++) sn[i] = SN_RESET;
      read_sn(OP_SN_RD, int'(RD_SKIP));
      // special commands without write enable are dropped
      for (int k = 0; k < 4; k++) begin
         send1(ops[k]);
         chk("no wen store", 32'h0, n_store);
         chk("no wen recall", 32'h0, n_recall);
         chk("no wen latch", 32'h0, {31'h0, wen});
         chk("no wen autosave", 32'h1, {31'h0, autosave});
      end
      for (int k = 0; k < 4; k++) begin
         send1(OP_WRITE_EN);
         chk("wen set", 32'h1, {31'h0, wen});
         ns = n_store;
         nr = n_recall;
         send1(ops[k]);
         chk("store pulses", ns + (k == 0), n_store);
         chk("recall pulses", nr + (k == 1), n_recall);
         chk("wen cleared", 32'h0, {31'h0, wen});
         chk("autosave", {31'h0, k != 2}, {31'h0, autosave});
         if (k >= 2) begin
            chk("busy after autosave cmd", 32'h1, {31'h0, busy});
            send1(OP_WRITE_EN);
            chk("frame refused while busy", 32'h0, {31'h0, wen});
            repeat (BUSY_CYC) @(posedge clk_sys);
         end
      end
      write_sn(1'b1);
      read_sn(OP_SN_FRD, int'(FRD_SKIP));
      pulse(1'b1);
      chk("lock set", 32'h1, {31'h0, lock});
      pulse(1'b0);
      chk("unstored lock clears", 32'h0, {31'h0, lock});
      pulse(1'b1);
      write_sn(1'b0);
      read_sn(OP_SN_RD, int'(RD_SKIP));
      send1(OP_WRITE_EN);
      send1(OP_STORE);
      chk("lock stored", 32'h1, {31'h0, lock_stored});
      pulse(1'b0);
      chk("stored lock stays", 32'h1, {31'h0, lock});
      // sleep entry with and without pending sram writes
      for (int w = 1; w >= 0; w--) begin
         sram_written = w[0];
         ns = n_store;
         send1(OP_SLEEP);
         chk("sleeping", 32'h1, {31'h0, sleeping});
         chk("sleep store", ns + w, n_store);
         host.tx[0] = OP_SN_RD;
         host.frame(3);
         chk("so off while asleep", 32'h0, {31'h0, host.oe_seen});
         chk("awake", 32'h0, {31'h0, sleeping});
         send1(OP_WRITE_EN);
         chk("usable after wake", 32'h1, {31'h0, wen});
      end
      // mid-run reset stands in for a power cycle; volatile state reverts
      send1(OP_AS_OFF);
      repeat (BUSY_CYC) @(posedge clk_sys);
      chk("autosave off before reset", 32'h0, {31'h0, autosave});
      @(posedge clk_sys) #2;
      sys_rst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #2 sys_rst = 1'b0;
      repeat (5) @(posedge clk_sys);
      chk("wen after reset", 32'h0, {31'h0, wen});
      chk("awake after reset", 32'h0, {31'h0, sleeping});
      chk("autosave after reset", 32'h1, {31'h0, autosave});
      ns = n_store;
      send1(OP_STORE);
      chk("no store after reset", ns, n_store);
      tally_and_finish();
   end
endmodule : nvsram_special_command_unit_test
